// file: tb/tb_top.sv
// self-checking bench for the event destination routing block
// assumes registered destination outputs and read data standing one cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import edr_pkg::*;
    logic        clk;
    logic        rst_n;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [7:0]  chan;
    logic        adc;
    logic        dac;
    logic [5:0]  tmr;
    logic [3:0]  mct;
    logic        mctg;
    logic        rtc;
    logic [3:0]  gpio;
    logic [17:0] dests;
    logic [17:0] exp_v;
    int          err_total;
    int          check_count;

    assign dests = {gpio, rtc, mctg, mct, tmr, dac, adc};

    edr_router uut (
        .CORE_CLK_IN       (clk),
        .RESETN_IN         (rst_n),
        .REG_ADDR_IN       (addr),
        .REG_WDATA_IN      (wdata),
        .REG_WR_IN         (wr),
        .REG_RD_IN         (rd),
        .REG_RDATA_OUT     (rdata),
        .EVENT_CHAN_IN     (chan),
        .DEST_ADC_CONV_OUT (adc),
        .DEST_DAC_CONV_OUT (dac),
        .DEST_TIMER_IN_OUT (tmr),
        .DEST_MCT_IN_OUT   (mct),
        .DEST_MCT_GEN_OUT  (mctg),
        .DEST_RTC_SRC_OUT  (rtc),
        .EVENT_GPIO_OUT    (gpio)
    );

    always #10 clk = ~clk;

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk({10'h000, rdata}, {10'h000, exp});
    endtask : rd_chk

    task automatic test_reset();
        chk(dests, 18'h00000);
        rd_chk(IDX_SEL_OFS, 8'h00);
        rd_chk(IND_DATA_OFS, 8'h00);
    endtask : test_reset

    task automatic test_reserved_bits();
        reg_wr(IDX_SEL_OFS, 8'h3f);
        rd_chk(IDX_SEL_OFS, 8'h3f);
        reg_wr(IND_DATA_OFS, 8'h0f);
        rd_chk(IND_DATA_OFS, 8'h0f);
        @(posedge clk);
        #1;
        chk({10'h000, rdata}, 18'h00000);
        reg_wr(12'h123, 8'h05);
        rd_chk(IDX_SEL_OFS, 8'h3f);
        rd_chk(12'h123, 8'h00);
    endtask : test_reserved_bits

    // every destination connected, pick cycling through all eight channels
    task automatic test_routing();
        for (int p = 0; p < 18; p++)
        begin
            reg_wr(IDX_SEL_OFS, {2'b00, DEST_CODES[p]});
            reg_wr(IND_DATA_OFS, 8'h08 | 8'(p % 8));
        end
        rd_chk(IND_DATA_OFS, 8'h09);
        reg_wr(IDX_SEL_OFS, 8'h05);
        reg_wr(IND_DATA_OFS, 8'h0c);
        reg_wr(IDX_SEL_OFS, 8'h04);
        rd_chk(IND_DATA_OFS, 8'h08);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            chan <= 8'h01 << k;
            repeat (2) @(posedge clk);
            #1;
            for (int p = 0; p < 18; p++)
                exp_v[p] = ((p % 8) == k);
            chk(dests, exp_v);
        end
    endtask : test_routing

    task automatic test_disconnect();
        for (int p = 0; p < 18; p++)
        begin
            reg_wr(IDX_SEL_OFS, {2'b00, DEST_CODES[p]});
            reg_wr(IND_DATA_OFS, 8'(p % 8));
        end
        @(posedge clk);
        chan <= 8'hff;
        repeat (2) @(posedge clk);
        #1;
        chk(dests, 18'h00000);
    endtask : test_disconnect

    initial
    begin
        // the tests need well under a thousand cycles; allow ten thousand
        #200000;
        err_total++;
        print_verdict();
    end

    initial
    begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        addr        = 12'h000;
        wdata       = 8'h00;
        wr          = 1'b0;
        rd          = 1'b0;
        chan        = 8'h00;
        err_total   = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_routing();
        // reset in mid-run with destinations live
        @(posedge clk);
        chan  <= 8'hff;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_disconnect();
        test_reserved_bits();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// file: verilog/edr_bus_decode.sv
// register port decode for the event destination routing block
// assumes strobes are single-cycle and never both high together
`timescale 1ns/1ps
`default_nettype none
module edr_bus_decode
    import edr_pkg::*;
(
    input  wire logic [11:0] addr_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic             idx_wr_out,
    output logic             idx_rd_out,
    output logic             data_wr_out,
    output logic             data_rd_out
);

    logic hit_idx;
    logic hit_data;

    assign hit_idx     = (addr_in == IDX_SEL_OFS);
    assign hit_data    = (addr_in == IND_DATA_OFS);
    assign idx_wr_out  = wr_in & hit_idx;
    assign idx_rd_out  = rd_in & hit_idx;
    assign data_wr_out = wr_in & hit_data;
    assign data_rd_out = rd_in & hit_data;

endmodule : edr_bus_decode
`default_nettype wire

// file: verilog/edr_pkg.sv
// constants shared by the event destination routing block
// assumes an 8-bit register port with 12-bit byte addresses
`default_nettype none
package edr_pkg;

    // register port shape
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // register offsets as printed
    localparam logic [11:0] IDX_SEL_OFS  = 12'hf9a;
    localparam logic [11:0] IND_DATA_OFS = 12'hf9b;

    // subregister array shape
    localparam int unsigned IDX_W    = 6;
    localparam int unsigned CFG_W    = 4;
    localparam int unsigned NUM_SUB  = 64;
    localparam int unsigned NUM_CHAN = 8;
    localparam int unsigned PICK_W   = 3;

    // field positions inside a destination subregister
    localparam int unsigned CONNECT_BIT = 3;
    localparam int unsigned PICK_LSB    = 0;

    // reset values
    localparam logic [5:0] IDX_SEL_RST = 6'h00;
    localparam logic [3:0] CFG_RST     = 4'h0;
    localparam logic [7:0] RDATA_IDLE  = 8'h00;

    // destinations that leave the block, and their subaddress codes
    localparam int unsigned NUM_DEST = 18;
    localparam int unsigned POS_ADC  = 0;
    localparam int unsigned POS_DAC  = 1;
    localparam int unsigned POS_TMR  = 2;
    localparam int unsigned NUM_TMR  = 6;
    localparam int unsigned POS_MCT  = 8;
    localparam int unsigned NUM_MCT  = 4;
    localparam int unsigned POS_MCTG = 12;
    localparam int unsigned POS_RTC  = 13;
    localparam int unsigned POS_GPIO = 14;
    localparam int unsigned NUM_GPIO = 4;

    // entry n holds the subaddress of destination position n
    localparam logic [17:0][5:0] DEST_CODES = {
        6'h33, 6'h32, 6'h31, 6'h30,
        6'h2c,
        6'h20,
        6'h1f, 6'h1e, 6'h1d, 6'h1c,
        6'h19, 6'h18, 6'h15, 6'h14, 6'h11, 6'h10,
        6'h08,
        6'h04
    };

endpackage : edr_pkg
`default_nettype wire

// file: verilog/edr_route_mux.sv
// picks one event channel for one destination, or logic zero
// assumes channel levels are synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module edr_route_mux
    import edr_pkg::*;
#(
    parameter int unsigned CHANS = NUM_CHAN
)
(
    input  wire logic [3:0]       cfg_in,
    input  wire logic [CHANS-1:0] chan_in,
    output logic                  route_out
);

    logic [2:0] pick;

    assign pick = cfg_in[PICK_LSB +: PICK_W];
    // unconnected destinations see logic zero
    assign route_out = cfg_in[CONNECT_BIT] & chan_in[pick];

endmodule : edr_route_mux
`default_nettype wire

// file: verilog/edr_router.sv
// What this block does
// R1: six-bit subaddress picks one of 64 subregisters
// R2: codes 04h and 08h feed ADC, DAC
// R3: codes 10h-19h pairs feed timer inputs
// R4: 1Ch-1Fh multi-channel inputs, 20h general input
// R5: code 2Ch feeds real-time clock source
// R6: codes 30h-33h feed event GPIO outputs
// R7: subaddress top bits read zero, write zero
// R8: subdata exposes four bits, upper four zero
// R9: subregister holds connect bit and channel pick
// R10: unconnected destination is held at zero
// R11: three-bit pick selects channel 0 to 7
// R12: subdata access touches only the selected subregister
//
// top of the event destination routing block
// assumes a single-cycle register port and synchronous event channels
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module edr_router
    import edr_pkg::*;
#(
    parameter int unsigned CHANS = NUM_CHAN
)
(
    input  wire logic                CORE_CLK_IN,
    input  wire logic                RESETN_IN,
    input  wire logic [11:0]         REG_ADDR_IN,
    input  wire logic [7:0]          REG_WDATA_IN,
    input  wire logic                REG_WR_IN,
    input  wire logic                REG_RD_IN,
    output logic      [7:0]          REG_RDATA_OUT,
    input  wire logic [CHANS-1:0]    EVENT_CHAN_IN,
    output logic                     DEST_ADC_CONV_OUT,
    output logic                     DEST_DAC_CONV_OUT,
    output logic      [NUM_TMR-1:0]  DEST_TIMER_IN_OUT,
    output logic      [NUM_MCT-1:0]  DEST_MCT_IN_OUT,
    output logic                     DEST_MCT_GEN_OUT,
    output logic                     DEST_RTC_SRC_OUT,
    output logic      [NUM_GPIO-1:0] EVENT_GPIO_OUT
);

    typedef struct packed {
        logic [5:0]          dest_index_select;
        logic [63:0][3:0]    dest_channel_config;
        logic [17:0]         dest;
        logic [7:0]          rdata;
    } edr_state_t;

    edr_state_t st_r;
    edr_state_t st_nxt;

    logic        idx_wr;
    logic        idx_rd;
    logic        data_wr;
    logic        data_rd;
    logic [17:0] route_vec;

    // subregister currently reached through the subdata register
    function automatic logic [3:0] sel_cfg(input logic [63:0][3:0] cfg, input logic [5:0] idx);
        sel_cfg = cfg[idx];
    endfunction : sel_cfg

    // level a destination should carry for a given subregister and channel set
    function automatic logic route_ref(input logic [3:0] cfg, input logic [CHANS-1:0] chan);
        route_ref = cfg[CONNECT_BIT] & chan[cfg[PICK_LSB +: PICK_W]];
    endfunction : route_ref

    edr_bus_decode u_dec
    (
        .addr_in     (REG_ADDR_IN),
        .wr_in       (REG_WR_IN),
        .rd_in       (REG_RD_IN),
        .idx_wr_out  (idx_wr),
        .idx_rd_out  (idx_rd),
        .data_wr_out (data_wr),
        .data_rd_out (data_rd)
    );

    // one channel mux per destination at its fixed subaddress
    genvar g;
    generate
        for (g = 0; g < NUM_DEST; g++)
        begin : g_dest
            edr_route_mux #(
                .CHANS (CHANS)
            ) u_mux
            (
                .cfg_in    (st_r.dest_channel_config[DEST_CODES[g]]), // R2 R3 R4 R5 R6 R9
                .chan_in   (EVENT_CHAN_IN),
                .route_out (route_vec[g])                              // R10 R11
            );
        end
    endgenerate

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.rdata = RDATA_IDLE;
        st_nxt.dest  = route_vec;
        if (idx_wr)
        begin
            st_nxt.dest_index_select = REG_WDATA_IN[IDX_W-1:0]; // R1 R7
        end
        if (data_wr)
        begin
            st_nxt.dest_channel_config[st_r.dest_index_select] = REG_WDATA_IN[CFG_W-1:0]; // R12
        end
        if (idx_rd)
        begin
            st_nxt.rdata = {2'h0, st_r.dest_index_select}; // R7
        end
        else if (data_rd)
        begin
            st_nxt.rdata = {4'h0, sel_cfg(st_r.dest_channel_config, st_r.dest_index_select)}; // R8 R12
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st_r.dest_index_select   <= IDX_SEL_RST;
            st_r.dest_channel_config <= {NUM_SUB{CFG_RST}};
            st_r.dest                <= '0;
            st_r.rdata               <= RDATA_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA_OUT     = st_r.rdata;
    assign DEST_ADC_CONV_OUT = st_r.dest[POS_ADC];
    assign DEST_DAC_CONV_OUT = st_r.dest[POS_DAC];
    assign DEST_TIMER_IN_OUT = st_r.dest[POS_TMR +: NUM_TMR];
    assign DEST_MCT_IN_OUT   = st_r.dest[POS_MCT +: NUM_MCT];
    assign DEST_MCT_GEN_OUT  = st_r.dest[POS_MCTG];
    assign DEST_RTC_SRC_OUT  = st_r.dest[POS_RTC];
    assign EVENT_GPIO_OUT    = st_r.dest[POS_GPIO +: NUM_GPIO];

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence data_wr_s;
        data_wr ##1 1'b1;
    endsequence

    sequence data_rd_s;
        data_rd ##1 1'b1;
    endsequence

    idx_write_a: assert property (idx_wr |=> st_r.dest_index_select == $past(REG_WDATA_IN[5:0])) // R1
        else $error("subaddress write not taken");

    idx_rsvd_a: assert property (idx_rd |=> REG_RDATA_OUT == {2'h0, $past(st_r.dest_index_select)}) // R7
        else $error("subaddress reserved bits not zero");

    data_rsvd_a: assert property (data_rd_s |-> // R8
        REG_RDATA_OUT == {4'h0, $past(st_r.dest_channel_config[st_r.dest_index_select])})
        else $error("subdata reserved bits not zero");

    sub_write_a: assert property (data_wr_s |-> // R12
        st_r.dest_channel_config[$past(st_r.dest_index_select)] == $past(REG_WDATA_IN[3:0]))
        else $error("subregister write lost");

    sub_keep_a: assert property (data_wr |=> // R12
        st_r.dest_channel_config[$past(st_r.dest_index_select) ^ 6'h01]
        == $past(st_r.dest_channel_config[st_r.dest_index_select ^ 6'h01]))
        else $error("unselected subregister changed");

    sub_read_a: assert property (data_rd_s |-> // R12
        REG_RDATA_OUT[3:0] == $past(sel_cfg(st_r.dest_channel_config, st_r.dest_index_select)))
        else $error("subdata read wrong value");

    rdata_idle_a: assert property (!(idx_rd || data_rd) |=> REG_RDATA_OUT == 8'h00) // R8
        else $error("read data outside read slot");

    adc_off_a: assert property (!st_r.dest_channel_config[6'h04][3] |=> DEST_ADC_CONV_OUT == 1'b0) // R10
        else $error("unconnected adc input not low");

    gpio_route_a: assert property (st_r.dest_channel_config[6'h33][3] |=> // R6
        EVENT_GPIO_OUT[3] == $past(EVENT_CHAN_IN[st_r.dest_channel_config[6'h33][2:0]]))
        else $error("gpio 3 not routed");

    rtc_route_a: assert property (##1 DEST_RTC_SRC_OUT == // R5
        $past(st_r.dest_channel_config[6'h2c][3] & EVENT_CHAN_IN[st_r.dest_channel_config[6'h2c][2:0]]))
        else $error("rtc source not routed");

    generate
        for (g = 0; g < NUM_DEST; g++)
        begin : g_chk
            route_a: assert property (##1 st_r.dest[g] == // R9 R10 R11 R3 R4 R2
                $past(st_r.dest_channel_config[DEST_CODES[g]][3]
                & EVENT_CHAN_IN[st_r.dest_channel_config[DEST_CODES[g]][2:0]]))
                else $error("destination route mismatch");
        end
    endgenerate

    // each destination follows the subregister at its own fixed code
    adc_route_a: assert property (##1 DEST_ADC_CONV_OUT == // R2
        $past(route_ref(st_r.dest_channel_config[6'h04], EVENT_CHAN_IN)))
        else $error("adc input not routed");

    dac_route_a: assert property (##1 DEST_DAC_CONV_OUT == // R2
        $past(route_ref(st_r.dest_channel_config[6'h08], EVENT_CHAN_IN)))
        else $error("dac input not routed");

    tmr0_route_a: assert property (##1 DEST_TIMER_IN_OUT[0] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h10], EVENT_CHAN_IN)))
        else $error("timer 0 input 0 not routed");

    tmr1_route_a: assert property (##1 DEST_TIMER_IN_OUT[1] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h11], EVENT_CHAN_IN)))
        else $error("timer 0 input 1 not routed");

    tmr2_route_a: assert property (##1 DEST_TIMER_IN_OUT[2] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h14], EVENT_CHAN_IN)))
        else $error("timer 1 input 0 not routed");

    tmr3_route_a: assert property (##1 DEST_TIMER_IN_OUT[3] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h15], EVENT_CHAN_IN)))
        else $error("timer 1 input 1 not routed");

    tmr4_route_a: assert property (##1 DEST_TIMER_IN_OUT[4] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h18], EVENT_CHAN_IN)))
        else $error("timer 2 input 0 not routed");

    tmr5_route_a: assert property (##1 DEST_TIMER_IN_OUT[5] == // R3
        $past(route_ref(st_r.dest_channel_config[6'h19], EVENT_CHAN_IN)))
        else $error("timer 2 input 1 not routed");

    mct0_route_a: assert property (##1 DEST_MCT_IN_OUT[0] == // R4
        $past(route_ref(st_r.dest_channel_config[6'h1c], EVENT_CHAN_IN)))
        else $error("multi-channel input a not routed");

    mct1_route_a: assert property (##1 DEST_MCT_IN_OUT[1] == // R4
        $past(route_ref(st_r.dest_channel_config[6'h1d], EVENT_CHAN_IN)))
        else $error("multi-channel input b not routed");

    mct2_route_a: assert property (##1 DEST_MCT_IN_OUT[2] == // R4
        $past(route_ref(st_r.dest_channel_config[6'h1e], EVENT_CHAN_IN)))
        else $error("multi-channel input c not routed");

    mct3_route_a: assert property (##1 DEST_MCT_IN_OUT[3] == // R4
        $past(route_ref(st_r.dest_channel_config[6'h1f], EVENT_CHAN_IN)))
        else $error("multi-channel input d not routed");

    mctg_route_a: assert property (##1 DEST_MCT_GEN_OUT == // R4
        $past(route_ref(st_r.dest_channel_config[6'h20], EVENT_CHAN_IN)))
        else $error("general multi-channel input not routed");

    gpio0_route_a: assert property (##1 EVENT_GPIO_OUT[0] == // R6
        $past(route_ref(st_r.dest_channel_config[6'h30], EVENT_CHAN_IN)))
        else $error("gpio 0 not routed");

    gpio1_route_a: assert property (##1 EVENT_GPIO_OUT[1] == // R6
        $past(route_ref(st_r.dest_channel_config[6'h31], EVENT_CHAN_IN)))
        else $error("gpio 1 not routed");

    gpio2_route_a: assert property (##1 EVENT_GPIO_OUT[2] == // R6
        $past(route_ref(st_r.dest_channel_config[6'h32], EVENT_CHAN_IN)))
        else $error("gpio 2 not routed");

    // a disconnected destination rests at zero whatever the channels do
    dac_off_a: assert property (!st_r.dest_channel_config[6'h08][3] |=> // R10
        DEST_DAC_CONV_OUT == 1'b0)
        else $error("unconnected dac input not low");

    tmr0_off_a: assert property (!st_r.dest_channel_config[6'h10][3] |=> // R10
        DEST_TIMER_IN_OUT[0] == 1'b0)
        else $error("unconnected timer 0 input 0 not low");

    tmr1_off_a: assert property (!st_r.dest_channel_config[6'h11][3] |=> // R10
        DEST_TIMER_IN_OUT[1] == 1'b0)
        else $error("unconnected timer 0 input 1 not low");

    tmr2_off_a: assert property (!st_r.dest_channel_config[6'h14][3] |=> // R10
        DEST_TIMER_IN_OUT[2] == 1'b0)
        else $error("unconnected timer 1 input 0 not low");

    tmr3_off_a: assert property (!st_r.dest_channel_config[6'h15][3] |=> // R10
        DEST_TIMER_IN_OUT[3] == 1'b0)
        else $error("unconnected timer 1 input 1 not low");

    tmr4_off_a: assert property (!st_r.dest_channel_config[6'h18][3] |=> // R10
        DEST_TIMER_IN_OUT[4] == 1'b0)
        else $error("unconnected timer 2 input 0 not low");

    tmr5_off_a: assert property (!st_r.dest_channel_config[6'h19][3] |=> // R10
        DEST_TIMER_IN_OUT[5] == 1'b0)
        else $error("unconnected timer 2 input 1 not low");

    mct0_off_a: assert property (!st_r.dest_channel_config[6'h1c][3] |=> // R10
        DEST_MCT_IN_OUT[0] == 1'b0)
        else $error("unconnected multi-channel input a not low");

    mct1_off_a: assert property (!st_r.dest_channel_config[6'h1d][3] |=> // R10
        DEST_MCT_IN_OUT[1] == 1'b0)
        else $error("unconnected multi-channel input b not low");

    mct2_off_a: assert property (!st_r.dest_channel_config[6'h1e][3] |=> // R10
        DEST_MCT_IN_OUT[2] == 1'b0)
        else $error("unconnected multi-channel input c not low");

    mct3_off_a: assert property (!st_r.dest_channel_config[6'h1f][3] |=> // R10
        DEST_MCT_IN_OUT[3] == 1'b0)
        else $error("unconnected multi-channel input d not low");

    mctg_off_a: assert property (!st_r.dest_channel_config[6'h20][3] |=> // R10
        DEST_MCT_GEN_OUT == 1'b0)
        else $error("unconnected general multi-channel input not low");

    rtc_off_a: assert property (!st_r.dest_channel_config[6'h2c][3] |=> // R10
        DEST_RTC_SRC_OUT == 1'b0)
        else $error("unconnected rtc source not low");

    gpio0_off_a: assert property (!st_r.dest_channel_config[6'h30][3] |=> // R10
        EVENT_GPIO_OUT[0] == 1'b0)
        else $error("unconnected gpio 0 not low");

    gpio1_off_a: assert property (!st_r.dest_channel_config[6'h31][3] |=> // R10
        EVENT_GPIO_OUT[1] == 1'b0)
        else $error("unconnected gpio 1 not low");

    gpio2_off_a: assert property (!st_r.dest_channel_config[6'h32][3] |=> // R10
        EVENT_GPIO_OUT[2] == 1'b0)
        else $error("unconnected gpio 2 not low");

    gpio3_off_a: assert property (!st_r.dest_channel_config[6'h33][3] |=> // R10
        EVENT_GPIO_OUT[3] == 1'b0)
        else $error("unconnected gpio 3 not low");

    // storage moves only on its own strobe
    idx_hold_a: assert property (!idx_wr |=> $stable(st_r.dest_index_select)) // R1
        else $error("subaddress moved without a write");

    cfg_hold_a: assert property (!data_wr |=> $stable(st_r.dest_channel_config)) // R12
        else $error("subregister moved without a subdata write");

endmodule : edr_router
`default_nettype wire
